// ==== verilog/cbs_bank_status.sv ====
// Processor status bits and bank selectors of the 4-bit core
`timescale 1ns/10ps

// Summary of operation
// - Two-bit nesting level; 00 is normal run, any interrupt accepted.
// - Level 01: only higher-priority requests accepted.
// - Level 10: no interrupt requests accepted.
// - Accepting an interrupt pushes the level, then raises it one step, stopping at 10.
// - Return from interrupt restores the level held before the interrupt.
// - Software may read and write the level by memory instructions.
// - Memory expansion set: bank selector supplies upper address nibble.
// - Memory expansion clear: fixed space, bank selector ignored.
// - Reset loads memory expansion from bit 7 of program word 0.
// - Vectored interrupt loads memory expansion from vector entry bit 7.
// - Register expansion set: register bank selector picks bank 0 to 3.
// - Register expansion clear: bank 0 always active.
// - Reset loads register expansion from bit 6 of program word 0.
// - Vectored interrupt loads register expansion from vector entry bit 6.
// - Memory bank selector is 4 bits, accepting only banks 0-3 and 15.
// - Memory bank selector loads by its select instruction or by a bank pop.
// - Register bank selector loads 0 to 3; upper two bits read 0.
// - Reset clears memory bank selector.
// - Reset clears register bank selector.
// - Combined bank byte pushes as one 8-bit transfer; a pop loads bits 5:4 and, only if that bank is accepted, bits 3:0.
// - Interrupt saves all status bits; return restores them together.
// - Effective bank is register expansion ANDed with selector.
module cbs_bank_status #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // Reset vector word
    input  wire logic [7:0]        boot_word,
    input  wire logic              boot_valid,
    // Interrupt accept and return
    input  wire logic              int_accept,
    input  wire logic [7:0]        vector_word,
    input  wire logic              return_from_interrupt_instr_exec,
    input  wire logic [3:0]        psw_restore,
    // Memory manipulation of the status nibble
    input  wire logic              psw_wr,
    input  wire logic [3:0]        psw_wdata,
    // Bank select instructions
    input  wire logic              sel_mbank,
    input  wire logic              sel_rbank,
    input  wire logic [3:0]        sel_operand,
    input  wire logic              pop_bank,
    input  wire logic [7:0]        pop_data,
    // Data address formation
    input  wire logic [ADDR_W-1:0] addr_in,
    // Status outputs
    output logic [3:0]             psw_nibble,
    output logic [3:0]             psw_push,
    output logic [7:0]             combined_bank_selector,
    output logic [1:0]             effective_reg_bank,
    output logic [ADDR_W-1:0]      data_addr,
    output logic                   accept_any,
    output logic                   accept_high_only,
    output logic                   ready
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    cbs_pkg::cbs_state_t state_q, state_d;
    logic [1:0]        int_level_q, int_level_d;
    logic              mem_expand_flag_q, mem_expand_flag_d;
    logic              reg_expand_flag_q, reg_expand_flag_d;
    logic [3:0]        memory_bank_selector_q, memory_bank_selector_d;
    logic [3:0]        register_bank_selector_q, register_bank_selector_d;
    logic [3:0]        psw_nibble_q, psw_nibble_d;
    logic [3:0]        psw_push_q, psw_push_d;
    logic [7:0]        cbs_q, cbs_d;
    logic [1:0]        erb_q, erb_d;
    logic [ADDR_W-1:0] daddr_q, daddr_d;
    logic              any_q, any_d;
    logic              high_q, high_d;
    logic              ready_q, ready_d;

    logic int_level_hi;
    logic int_level_lo;

    function automatic logic mbank_ok(input logic [3:0] n);
        mbank_ok = (n <= cbs_pkg::MBANK_TOP) || (n == cbs_pkg::MBANK_IO);
    endfunction : mbank_ok

    // ------------------------------------------------------------
    // Boot sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            cbs_pkg::ST_BOOT: begin
                if (boot_valid) begin
                    state_d = cbs_pkg::ST_RUN;
                end
            end
            cbs_pkg::ST_RUN: begin
                state_d = cbs_pkg::ST_RUN;
            end
            default: begin
                state_d = cbs_pkg::ST_BOOT;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= cbs_pkg::ST_BOOT;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Interrupt nesting level
    // ------------------------------------------------------------
    always_comb begin
        int_level_d = int_level_q;
        if (state_q == cbs_pkg::ST_RUN) begin
            if (int_accept) begin
                // Level 10 is the ceiling; a software-written 11 stays as it is
                if (int_level_q < cbs_pkg::LVL_TWO) begin
                    int_level_d = int_level_q + cbs_pkg::LVL_ONE;
                end
            end else if (return_from_interrupt_instr_exec) begin
                int_level_d = {psw_restore[cbs_pkg::PSW_LVL_HI],
                               psw_restore[cbs_pkg::PSW_LVL_LO]};
            end else if (psw_wr) begin
                int_level_d = {psw_wdata[cbs_pkg::PSW_LVL_HI],
                               psw_wdata[cbs_pkg::PSW_LVL_LO]};
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            int_level_q <= cbs_pkg::LVL_NORMAL;
        end else begin
            int_level_q <= int_level_d;
        end
    end

    // ------------------------------------------------------------
    // Memory and register expansion flags
    // ------------------------------------------------------------
    always_comb begin
        mem_expand_flag_d = mem_expand_flag_q;
        reg_expand_flag_d = reg_expand_flag_q;
        if (state_q != cbs_pkg::ST_RUN) begin
            if (boot_valid) begin
                mem_expand_flag_d = boot_word[cbs_pkg::VEC_MEM_BIT];
                reg_expand_flag_d = boot_word[cbs_pkg::VEC_REG_BIT];
            end
        end else if (int_accept) begin
            mem_expand_flag_d = vector_word[cbs_pkg::VEC_MEM_BIT];
            reg_expand_flag_d = vector_word[cbs_pkg::VEC_REG_BIT];
        end else if (return_from_interrupt_instr_exec) begin
            mem_expand_flag_d = psw_restore[cbs_pkg::PSW_MEM_BIT];
            reg_expand_flag_d = psw_restore[cbs_pkg::PSW_REG_BIT];
        end else if (psw_wr) begin
            mem_expand_flag_d = psw_wdata[cbs_pkg::PSW_MEM_BIT];
            reg_expand_flag_d = psw_wdata[cbs_pkg::PSW_REG_BIT];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_expand_flag_q <= 1'b0;
            reg_expand_flag_q <= 1'b0;
        end else begin
            mem_expand_flag_q <= mem_expand_flag_d;
            reg_expand_flag_q <= reg_expand_flag_d;
        end
    end

    // ------------------------------------------------------------
    // Status snapshot for the stack
    // ------------------------------------------------------------
    always_comb begin
        psw_push_d = psw_push_q;
        if ((state_q == cbs_pkg::ST_RUN) && int_accept) begin
            psw_push_d = psw_nibble_q;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            psw_push_q <= 4'h0;
        end else begin
            psw_push_q <= psw_push_d;
        end
    end

    // ------------------------------------------------------------
    // Bank selectors
    // ------------------------------------------------------------
    always_comb begin
        memory_bank_selector_d   = memory_bank_selector_q;
        register_bank_selector_d = register_bank_selector_q;
        if (state_q == cbs_pkg::ST_RUN) begin
            // A refused select operand still outranks a pop in the same cycle
            if (sel_mbank) begin
                if (mbank_ok(sel_operand)) begin
                    memory_bank_selector_d = sel_operand;
                end
            end else if (pop_bank && mbank_ok(pop_data[3:0])) begin
                memory_bank_selector_d = pop_data[3:0];
            end
            if (sel_rbank) begin
                register_bank_selector_d = {cbs_pkg::UPPER_ZERO,
                                            sel_operand[1:0]};
            end else if (pop_bank) begin
                register_bank_selector_d = {cbs_pkg::UPPER_ZERO,
                                            pop_data[5:4]};
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            memory_bank_selector_q   <= cbs_pkg::MBS_RESET;
            register_bank_selector_q <= cbs_pkg::RBS_RESET;
        end else begin
            memory_bank_selector_q   <= memory_bank_selector_d;
            register_bank_selector_q <= register_bank_selector_d;
        end
    end

    assign int_level_hi = int_level_d[1];
    assign int_level_lo = int_level_d[0];

    // ------------------------------------------------------------
    // Status and acceptance outputs
    // ------------------------------------------------------------
    always_comb begin
        psw_nibble_d = {int_level_hi, int_level_lo, mem_expand_flag_d, reg_expand_flag_d};
        any_d        = (int_level_d == cbs_pkg::LVL_NORMAL);
        high_d       = (int_level_d == cbs_pkg::LVL_ONE);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            psw_nibble_q <= 4'h0;
            any_q        <= 1'b0;
            high_q       <= 1'b0;
        end else begin
            psw_nibble_q <= psw_nibble_d;
            any_q        <= any_d;
            high_q       <= high_d;
        end
    end

    // ------------------------------------------------------------
    // Bank and address outputs
    // ------------------------------------------------------------
    always_comb begin
        cbs_d = {register_bank_selector_d, memory_bank_selector_d};
        if (reg_expand_flag_d) begin
            erb_d = register_bank_selector_d[1:0];
        end else begin
            erb_d = cbs_pkg::RBANK_ZERO;
        end
        if (mem_expand_flag_d) begin
            daddr_d = {memory_bank_selector_d, addr_in[ADDR_W-5:0]};
        end else begin
            daddr_d = addr_in;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cbs_q   <= 8'h00;
            erb_q   <= cbs_pkg::RBANK_ZERO;
            daddr_q <= '0;
        end else begin
            cbs_q   <= cbs_d;
            erb_q   <= erb_d;
            daddr_q <= daddr_d;
        end
    end

    // ------------------------------------------------------------
    // Ready flag
    // ------------------------------------------------------------
    always_comb begin
        ready_d = (state_d == cbs_pkg::ST_RUN);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= ready_d;
        end
    end

    assign psw_nibble             = psw_nibble_q;
    assign psw_push               = psw_push_q;
    assign combined_bank_selector = cbs_q;
    assign effective_reg_bank     = erb_q;
    assign data_addr              = daddr_q;
    assign accept_any             = any_q;
    assign accept_high_only       = high_q;
    assign ready                  = ready_q;

endmodule : cbs_bank_status

// ==== shared/cbs_pkg.sv ====
// Constants and types for the bank select and interrupt status block
package cbs_pkg;
    // ------------------------------------------------------------
    // Interrupt nesting levels
    // ------------------------------------------------------------
    localparam logic [1:0] LVL_NORMAL = 2'h0;
    localparam logic [1:0] LVL_ONE    = 2'h1;
    localparam logic [1:0] LVL_TWO    = 2'h2;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int VEC_MEM_BIT  = 7;
    localparam int VEC_REG_BIT  = 6;
    localparam int PSW_LVL_HI   = 3;
    localparam int PSW_LVL_LO   = 2;
    localparam int PSW_MEM_BIT  = 1;
    localparam int PSW_REG_BIT  = 0;
    // ------------------------------------------------------------
    // Reset values and bank limits
    // ------------------------------------------------------------
    localparam logic [3:0] MBS_RESET    = 4'h0;
    localparam logic [3:0] RBS_RESET    = 4'h0;
    localparam logic [3:0] MBANK_TOP    = 4'h3;
    localparam logic [3:0] MBANK_IO     = 4'hf;
    localparam logic [1:0] RBANK_ZERO   = 2'h0;
    localparam logic [1:0] UPPER_ZERO   = 2'h0;
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_BOOT = 2'b01,
        ST_RUN  = 2'b10
    } cbs_state_t;
endpackage : cbs_pkg

// ==== tb/cbs_seq_model.sv ====
// Sequencer model that fetches the reset vector word after reset
`timescale 1ns/10ps
module cbs_seq_model #(
    parameter int DELAY = 3
) (
    // Clock, reset and word to present
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] word,
    // Boot word towards the block
    output logic [7:0]      boot_word,
    output logic            boot_valid
);
    int cnt;
    // One valid cycle per reset; outside it the word lines show garbage
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt        <= 0;
            boot_valid <= 1'b0;
            boot_word  <= ~word;
        end else begin
            if (cnt <= DELAY) cnt <= cnt + 1;
            boot_valid <= (cnt == DELAY);
            boot_word  <= (cnt == DELAY) ? word : ~word;
        end
    end
endmodule : cbs_seq_model

// ==== tb/cbs_bank_status_asserts.sv ====
// Concurrent checks on the bank select and status block ports
`timescale 1ns/10ps
module cbs_bank_status_asserts (
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset_n,
    // Requests seen by the block
    input wire logic       int_accept,
    input wire logic [7:0] vector_word,
    input wire logic       return_from_interrupt_instr_exec,
    input wire logic [3:0] psw_restore,
    input wire logic       psw_wr,
    input wire logic [3:0] psw_wdata,
    input wire logic       sel_mbank,
    input wire logic [3:0] sel_operand,
    // Block outputs
    input wire logic [3:0] psw_nibble,
    input wire logic [3:0] psw_push,
    input wire logic [7:0] combined_bank_selector,
    input wire logic [1:0] effective_reg_bank,
    input wire logic       accept_any,
    input wire logic       accept_high_only,
    input wire logic       ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_int;
        ready && int_accept;
    endsequence
    sequence s_ret;
        ready && return_from_interrupt_instr_exec && !int_accept;
    endsequence
    sequence s_wr;
        ready && psw_wr && !int_accept && !return_from_interrupt_instr_exec;
    endsequence
    sequence s_bad_mb;
        ready && sel_mbank && sel_operand > 4'h3 && sel_operand != 4'hf;
    endsequence
    any_lvl_a: assert property (
        ready |-> accept_any == (psw_nibble[3:2] == 2'h0))
        else $error("accept any wrong");
    high_lvl_a: assert property (
        ready |-> accept_high_only == (psw_nibble[3:2] == 2'h1))
        else $error("accept high wrong");
    top_lvl_a: assert property (
        ready && psw_nibble[3:2] == 2'h2 |-> !accept_any && !accept_high_only)
        else $error("level two accepts");
    int_push_a: assert property (
        s_int |=> psw_push == $past(psw_nibble))
        else $error("pushed nibble wrong");
    int_step_a: assert property (
        s_int ##0 !psw_nibble[3] |=> psw_nibble[3:2] == $past(psw_nibble[3:2]) + 2'h1)
        else $error("level not advanced");
    int_cap_a: assert property (
        s_int ##0 psw_nibble[3:2] == 2'h2 |=> psw_nibble[3:2] == 2'h2)
        else $error("level passed two");
    vec_flags_a: assert property (
        s_int |=> psw_nibble[1:0] == $past(vector_word[7:6]))
        else $error("vector flags wrong");
    return_from_interrupt_instr_a: assert property (
        s_ret |=> psw_nibble == $past(psw_restore))
        else $error("return restore wrong");
    sw_wr_a: assert property (
        s_wr |=> psw_nibble == $past(psw_wdata))
        else $error("status write wrong");
    reg_bank_a: assert property (
        effective_reg_bank == (psw_nibble[0] ? combined_bank_selector[5:4] : 2'h0))
        else $error("effective bank wrong");
    rbs_top_a: assert property (
        combined_bank_selector[7:6] == 2'h0)
        else $error("bank upper bits set");
    mbs_bad_a: assert property (
        s_bad_mb |=> $stable(combined_bank_selector[3:0]))
        else $error("bad bank taken");
endmodule : cbs_bank_status_asserts
bind cbs_bank_status cbs_bank_status_asserts i_chk (.*);

// ==== tb/cbs_bank_status_tb_top.sv ====
// Self-checking bench for the bank select and status block
`timescale 1ns/10ps
module cbs_bank_status_tb_top;
    logic clk = 1'b0, reset_n = 1'b0, int_accept = 1'b0, return_from_interrupt_instr_exec = 1'b0, psw_wr = 1'b0;
    logic sel_mbank = 1'b0, sel_rbank = 1'b0, pop_bank = 1'b0, boot_valid, ready;
    logic accept_any, accept_high_only;
    logic [7:0] boot_w = 8'h00, boot_word, vector_word = 8'h00, pop_data = 8'h00;
    logic [7:0] combined_bank_selector;
    logic [3:0] psw_restore = 4'h0, psw_wdata = 4'h0, sel_operand = 4'h0, psw_nibble, psw_push;
    logic [11:0] addr_in = 12'h5a7, data_addr;
    logic [1:0] effective_reg_bank;
    int fails = 0, n_compared = 0;
    always #4 clk = ~clk;
    cbs_seq_model #(.DELAY(3)) i_seq (.clk(clk), .reset_n(reset_n), .word(boot_w),
        .boot_word(boot_word), .boot_valid(boot_valid));
    cbs_bank_status i_dut (.*);
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("fails=%0d n_compared=%0d", fails, n_compared);
        if (fails == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
        tick();
    endtask : pulse
    task automatic boot(input logic [7:0] w, input logic [3:0] exp);
        int i;
        reset_n = 1'b0;
        boot_w = w;
        repeat (16) tick();
        reset_n = 1'b1;
        chk(combined_bank_selector, 12'h0);
        for (i = 0; i < 20 && ready !== 1'b1; i++) tick();
        if (ready !== 1'b1) begin
            chk(ready, 1'b1);
            finish_test();
        end
        chk(psw_nibble, exp);
    endtask : boot
    task automatic t_int();
        vector_word = 8'hc0;
        pulse(int_accept);
        chk({psw_push, psw_nibble, 3'h0, accept_high_only}, 12'h071);
        vector_word = 8'h00;
        pulse(int_accept);
        chk({psw_push, psw_nibble, 2'h0, accept_any, accept_high_only}, 12'h780);
        vector_word = 8'h80;
        pulse(int_accept);
        chk(psw_nibble, 4'ha);
        psw_restore = 4'h7;
        pulse(return_from_interrupt_instr_exec);
        chk(psw_nibble, 4'h7);
        psw_restore = 4'h0;
        pulse(return_from_interrupt_instr_exec);
        chk(accept_any, 1'b1);
    endtask : t_int
    task automatic t_wr();
        int i;
        // Interrupts stay off while the level is written
        for (i = 2; i >= 0; i--) begin
            psw_wdata = {i[1:0], 2'h3};
            pulse(psw_wr);
            chk(psw_nibble, psw_wdata);
            chk({accept_any, accept_high_only}, {i == 0, i == 1});
        end
    endtask : t_wr
    task automatic t_bank();
        int i;
        logic [3:0] m;
        m = 4'h0;
        for (i = 0; i < 16; i++) begin
            sel_operand = i[3:0];
            pulse(sel_mbank);
            if (i < 4 || i == 15) m = i[3:0];
            chk({combined_bank_selector[3:0], data_addr[7:0]}, {m, addr_in[7:0]});
            chk(data_addr, {m, addr_in[7:0]});
        end
        for (i = 0; i < 4; i++) begin
            sel_operand = i[3:0];
            pulse(sel_rbank);
            chk(combined_bank_selector[7:4], i[3:0]);
            chk(effective_reg_bank, i[1:0]);
        end
        pop_data = 8'hf2;
        pulse(pop_bank);
        chk(combined_bank_selector, 8'h32);
        pop_data = 8'h15;
        pulse(pop_bank);
        chk(combined_bank_selector, 8'h12);
        psw_wdata = 4'h0;
        pulse(psw_wr);
        chk(effective_reg_bank, 2'h0);
        chk(data_addr, addr_in);
    endtask : t_bank
    initial begin
        boot(8'h80, 4'h2);
        boot(8'h00, 4'h0);
        t_int();
        t_wr();
        t_bank();
        boot(8'h40, 4'h1);
        finish_test();
    end
endmodule : cbs_bank_status_tb_top
